// ===== design/fpc_sync2.sv
// Two-stage synchroniser for a pin input
// Assumes the input is asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module fpc_sync2
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_ff;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= 1'b0;
      q_o     <= 1'b0;
    end
    else
    begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule // fpc_sync2
`default_nettype wire

// ===== design/fpc_timer.sv
// Interval timer counting programmed units of a fixed cycle length
// Assumes start and stop are one-cycle pulses from the same clock
`timescale 1ns/100ps
`default_nettype none
`include "fpc_map.svh"
module fpc_timer
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       stop_i,
  input  wire logic [7:0] units_i,
  output logic            busy_o,
  output logic            done_o
);
  localparam logic [15:0] UNIT_LAST = 16'(`FPC_UNIT_CYC - 1);
  logic [15:0] pre_ff;
  logic [7:0]  left_ff;

  // Prescaler and unit count; zero units expire on the next edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i || stop_i)
    begin
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      pre_ff  <= 16'h0000;
      left_ff <= 8'h00;
    end
    else if (start_i)
    begin
      busy_o  <= 1'b1;
      done_o  <= 1'b0;
      pre_ff  <= 16'h0000;
      left_ff <= units_i;
    end
    else
    begin
      done_o <= 1'b0;
      if (busy_o)
      begin
        if (left_ff == 8'h00)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        else if (pre_ff == UNIT_LAST)
        begin
          pre_ff  <= 16'h0000;
          left_ff <= left_ff - 8'h01;
        end
        else
        begin
          pre_ff <= pre_ff + 16'h0001;
        end
      end
    end
  end
endmodule // fpc_timer
`default_nettype wire

// ===== design/fpc_top.sv
// Floppy command parameter store and execution sequencer
// Assumes a classic Wishbone master and a drive giving one strobe per byte
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "fpc_map.svh"
module fpc_top
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        byte_rdy_i,
  output logic             head_load_o,
  output logic             side_o,
  output logic             step_o,
  output logic             dir_o,
  output logic             mfm_o,
  output logic             write_o,
  output logic             fifo_en_o,
  output logic      [3:0]  fifo_thr_o,
  output logic      [7:0]  precomp_trk_o,
  output logic      [7:0]  gap2_o,
  output logic      [7:0]  gap3_o,
  output logic             host_byte_o,
  output logic             fill_byte_o
);
  localparam logic [9:0] STEP_LAST = 10'(`FPC_STEP_CYC - 1);

  fpc_pkg::fpc_state_t st_ff;
  logic [31:0] cfg_ff, tim_ff, cmda_ff, cmdb_ff;
  logic [7:0]  ex_cyl_ff, ex_eot_ff, ex_gpl_ff, ex_gap2_ff, ex_dtl_ff, ex_hut_ff;
  logic [7:0]  cur_sec_ff, pcn_ff;
  logic [2:0]  ex_n_ff;
  logic        ex_mt_ff, ex_mfm_ff, ex_wr_ff, ex_perp_ff, cur_head_ff;
  logic        head_ff, hl_start_ff, hu_start_ff;
  logic [9:0]  step_cnt_ff;
  logic [14:0] byte_idx_ff;
  logic [15:0] host_cnt_ff;
  logic        rdy_s, rdy_d_ff, byte_ev;
  logic        hl_done_w, hu_done_w, hu_busy_w;
  logic        bus_req, bus_wr;
  logic [31:0] wmask;
  logic        go_w, soft_rst_w, last_byte_w, seek_need_w;
  fpc_pkg::fpc_len_t sect_len_w, host_len_w;

  ////////////////////////////////////////////////////////////////////////////
  // Drive byte strobe, synchronised then edge detected
  fpc_sync2 u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (byte_rdy_i),
    .q_o   (rdy_s)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdy_d_ff <= 1'b0;
    else
      rdy_d_ff <= rdy_s;
  end
  assign byte_ev = rdy_s & ~rdy_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone decode; one wait state, ack drops the cycle after
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i;
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] msk);
    merge = ((old & ~wmask) | (wb_dat_i & wmask)) & msk;
  endfunction

  // Either reset bit counts as a software reset, never a hardware one
  assign soft_rst_w = bus_wr && wb_adr_i == `FPC_A_CTRL && wb_sel_i[0] &&
                      (wb_dat_i[`FPC_CTRL_ORST] || wb_dat_i[`FPC_CTRL_RRST]);
  // Start is ignored while a command runs
  assign go_w = bus_wr && wb_adr_i == `FPC_A_CTRL && wb_sel_i[0] &&
                wb_dat_i[`FPC_CTRL_GO] && !soft_rst_w && st_ff == fpc_pkg::ST_IDLE;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= bus_req;
  end

  // Read mux; unmapped offsets read zero and ignore writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h00000000;
    else if (bus_req && !wb_we_i)
    begin
      case (wb_adr_i)
        `FPC_A_CFG:  wb_dat_o <= cfg_ff;
        `FPC_A_TIM:  wb_dat_o <= tim_ff;
        `FPC_A_CMDA: wb_dat_o <= cmda_ff;
        `FPC_A_CMDB: wb_dat_o <= cmdb_ff;
        `FPC_A_STAT: wb_dat_o <= {3'h0, st_ff, pcn_ff, cur_sec_ff, 5'h00, cur_head_ff, head_ff,
                                  st_ff != fpc_pkg::ST_IDLE};
        `FPC_A_CNT:  wb_dat_o <= {16'h0000, host_cnt_ff};
        default:     wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word; lock guards it against software reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cfg_ff <= {16'h0000, `FPC_PRE_RST, 2'b00, `FPC_THR_RST, 1'b0, `FPC_FDIS_RST};
    else if (soft_rst_w && !cfg_ff[`FPC_CFG_LOCK])
      cfg_ff <= {16'h0000, `FPC_PRE_RST, 1'b0, 1'b0, `FPC_THR_RST, cfg_ff[`FPC_CFG_SEEK],
                 `FPC_FDIS_RST};
    else if (bus_wr && wb_adr_i == `FPC_A_CFG)
      cfg_ff <= merge(cfg_ff, `FPC_CFG_MASK);
  end

  // Head intervals and the command words; host may rewrite them any time
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tim_ff  <= 32'h00000000;
      cmda_ff <= 32'h00000000;
      cmdb_ff <= 32'h00000000;
    end
    else if (bus_wr)
    begin
      if (wb_adr_i == `FPC_A_TIM)
        tim_ff <= merge(tim_ff, `FPC_TIM_MASK);
      if (wb_adr_i == `FPC_A_CMDA)
        cmda_ff <= merge(cmda_ff, `FPC_CMDA_MASK);
      if (wb_adr_i == `FPC_A_CMDB)
        cmdb_ff <= merge(cmdb_ff, `FPC_CMDB_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter snapshot at start, untouched until the next start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ex_cyl_ff  <= 8'h00;
      ex_eot_ff  <= 8'h00;
      ex_gpl_ff  <= 8'h00;
      ex_gap2_ff <= 8'h00;
      ex_dtl_ff  <= 8'h00;
      ex_hut_ff  <= 8'h00;
      ex_n_ff    <= 3'h0;
      ex_mt_ff   <= 1'b0;
      ex_mfm_ff  <= 1'b0;
      ex_wr_ff   <= 1'b0;
      ex_perp_ff <= 1'b0;
    end
    else if (go_w)
    begin
      ex_cyl_ff  <= cmda_ff[7:0];
      ex_eot_ff  <= cmdb_ff[7:0];
      ex_gpl_ff  <= cmdb_ff[15:8];
      ex_gap2_ff <= cmdb_ff[23:16];
      ex_perp_ff <= cmdb_ff[`FPC_CMDB_PERP];
      ex_dtl_ff  <= cmdb_ff[31:24];
      ex_hut_ff  <= tim_ff[15:8];
      ex_n_ff    <= cmda_ff[26:24];
      ex_mt_ff   <= cmda_ff[`FPC_CMDA_MT];
      ex_mfm_ff  <= cmda_ff[`FPC_CMDA_MFM];
      ex_wr_ff   <= cmda_ff[`FPC_CMDA_WR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sector length and host byte count
  assign sect_len_w  = fpc_pkg::fpc_len_t'(`FPC_BASE_LEN << ex_n_ff);
  // Code zero moves only the special length, capped at the 128-byte sector
  assign host_len_w  = (ex_n_ff != 3'h0) ? sect_len_w :
                       (ex_dtl_ff > 8'h80) ? `FPC_BASE_LEN : {7'h00, ex_dtl_ff};
  assign last_byte_w = byte_idx_ff == sect_len_w - 15'h0001;
  assign seek_need_w = cfg_ff[`FPC_CFG_SEEK] && cmda_ff[7:0] != pcn_ff;

  // Head timers; load timer runs after every seek, and otherwise only when the head is not down with the unload timer running
  fpc_timer u_hl
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (hl_start_ff),
    .stop_i  (soft_rst_w),
    .units_i (tim_ff[7:0]),
    .busy_o  (),
    .done_o  (hl_done_w)
  );

  fpc_timer u_hu
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (hu_start_ff),
    .stop_i  (soft_rst_w | go_w),
    .units_i (ex_hut_ff),
    .busy_o  (hu_busy_w),
    .done_o  (hu_done_w)
  );

  // Head load flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_w)
      head_ff <= 1'b0;
    else if (hl_start_ff)
      head_ff <= 1'b1;
    else if (hu_done_w && st_ff == fpc_pkg::ST_IDLE)
      head_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer: seek, head load, sector transfer, done
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst_w)
    begin
      st_ff       <= fpc_pkg::ST_IDLE;
      hl_start_ff <= 1'b0;
      hu_start_ff <= 1'b0;
      step_o      <= 1'b0;
      step_cnt_ff <= 10'h000;
      cur_sec_ff  <= 8'h00;
      cur_head_ff <= 1'b0;
      byte_idx_ff <= 15'h0000;
      host_cnt_ff <= 16'h0000;
      host_byte_o <= 1'b0;
      fill_byte_o <= 1'b0;
    end
    else
    begin
      hl_start_ff <= 1'b0;
      hu_start_ff <= 1'b0;
      step_o      <= 1'b0;
      host_byte_o <= 1'b0;
      fill_byte_o <= 1'b0;
      case (st_ff)
        fpc_pkg::ST_IDLE:
        begin
          if (go_w)
          begin
            cur_sec_ff  <= cmda_ff[23:16];
            cur_head_ff <= cmda_ff[`FPC_CMDA_HEAD];
            byte_idx_ff <= 15'h0000;
            host_cnt_ff <= 16'h0000;
            step_cnt_ff <= 10'h000;
            if (seek_need_w)
              st_ff <= fpc_pkg::ST_SEEK;
            else if (head_ff && hu_busy_w)
              st_ff <= fpc_pkg::ST_XFER;
            else
            begin
              st_ff       <= fpc_pkg::ST_HLOAD;
              hl_start_ff <= 1'b1;
            end
          end
        end
        fpc_pkg::ST_SEEK:
        begin
          if (pcn_ff == ex_cyl_ff)
          begin
            st_ff       <= fpc_pkg::ST_HLOAD;
            hl_start_ff <= 1'b1;
          end
          else if (step_cnt_ff == STEP_LAST)
          begin
            step_cnt_ff <= 10'h000;
            step_o      <= 1'b1;
          end
          else
            step_cnt_ff <= step_cnt_ff + 10'h001;
        end
        fpc_pkg::ST_HLOAD:
        begin
          if (hl_done_w)
            st_ff <= fpc_pkg::ST_XFER;
        end
        fpc_pkg::ST_XFER:
        begin
          if (byte_ev)
          begin
            // Beyond the host count: reads discard, writes put zero bytes
            if (byte_idx_ff < host_len_w)
            begin
              host_byte_o <= 1'b1;
              host_cnt_ff <= host_cnt_ff + 16'h0001;
            end
            else
              fill_byte_o <= 1'b1;
            if (!last_byte_w)
              byte_idx_ff <= byte_idx_ff + 15'h0001;
            else
            begin
              byte_idx_ff <= 15'h0000;
              if (cur_sec_ff != ex_eot_ff)
                cur_sec_ff <= cur_sec_ff + 8'h01;
              else if (ex_mt_ff && !cur_head_ff)
              begin
                cur_head_ff <= 1'b1;
                cur_sec_ff  <= `FPC_FIRST_SEC;
              end
              else
                st_ff <= fpc_pkg::ST_DONE;
            end
          end
        end
        fpc_pkg::ST_DONE:
        begin
          hu_start_ff <= 1'b1;
          st_ff       <= fpc_pkg::ST_IDLE;
        end
        default:
          st_ff <= fpc_pkg::ST_IDLE;
      endcase
    end
  end

  // Present cylinder follows every step pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pcn_ff <= 8'h00;
    else if (step_o)
      pcn_ff <= dir_o ? pcn_ff + 8'h01 : pcn_ff - 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered drive and data path controls
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      head_load_o   <= 1'b0;
      side_o        <= 1'b0;
      dir_o         <= 1'b0;
      mfm_o         <= 1'b0;
      write_o       <= 1'b0;
      fifo_en_o     <= 1'b0;
      fifo_thr_o    <= 4'h0;
      precomp_trk_o <= 8'h00;
      gap2_o        <= 8'h00;
      gap3_o        <= 8'h00;
    end
    else
    begin
      head_load_o   <= head_ff;
      side_o        <= cur_head_ff;
      dir_o         <= ex_cyl_ff > pcn_ff;
      mfm_o         <= ex_mfm_ff;
      write_o       <= ex_wr_ff && st_ff == fpc_pkg::ST_XFER;
      fifo_en_o     <= !cfg_ff[`FPC_CFG_FDIS];
      fifo_thr_o    <= cfg_ff[5:2];
      precomp_trk_o <= cfg_ff[15:8];
      gap2_o        <= ex_perp_ff ? ex_gap2_ff : `FPC_GAP2_DEF;
      gap3_o        <= ex_gpl_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_sec_end;
    st_ff == fpc_pkg::ST_XFER && byte_ev && last_byte_w && !soft_rst_w;
  endsequence
  sequence s_busy2;
    st_ff != fpc_pkg::ST_IDLE && $past(st_ff) != fpc_pkg::ST_IDLE;
  endsequence

  property p_fifo;
    ##1 (fifo_en_o == !$past(cfg_ff[`FPC_CFG_FDIS]));
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo enable wrong");

  property p_seek;
    // First step comes a full step spacing after entry, so the window spans it
    (go_w && seek_need_w) |=> st_ff == fpc_pkg::ST_SEEK ##[1:510] (step_o || st_ff != fpc_pkg::ST_SEEK);
  endproperty
  a_seek: assert property (p_seek) else $error("implied seek missing");

  property p_eot;
    (s_sec_end and (cur_sec_ff == ex_eot_ff && !(ex_mt_ff && !cur_head_ff)))
      |=> st_ff == fpc_pkg::ST_DONE ##1 hu_start_ff;
  endproperty
  a_eot: assert property (p_eot) else $error("no stop at last sector");

  property p_mt;
    (s_sec_end and (cur_sec_ff == ex_eot_ff && ex_mt_ff && !cur_head_ff))
      |=> cur_head_ff && cur_sec_ff == `FPC_FIRST_SEC && st_ff == fpc_pkg::ST_XFER;
  endproperty
  a_mt: assert property (p_mt) else $error("multi-track head switch wrong");

  property p_gap;
    s_busy2 |-> gap3_o == ex_gpl_ff && gap2_o == (ex_perp_ff ? ex_gap2_ff : `FPC_GAP2_DEF);
  endproperty
  a_gap: assert property (p_gap) else $error("gap output wrong");

  property p_hlt;
    (st_ff == fpc_pkg::ST_HLOAD && !hl_done_w) |=> st_ff != fpc_pkg::ST_XFER;
  endproperty
  a_hlt: assert property (p_hlt) else $error("transfer before head load time");

  property p_hut;
    $fell(head_ff) |-> $past(hu_done_w) || $past(soft_rst_w);
  endproperty
  a_hut: assert property (p_hut) else $error("head unloaded early");

  property p_lock;
    (soft_rst_w && cfg_ff[`FPC_CFG_LOCK]) |=> $stable(cfg_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("locked config changed");

  property p_unlock;
    (soft_rst_w && !cfg_ff[`FPC_CFG_LOCK])
      |=> cfg_ff[`FPC_CFG_FDIS] == `FPC_FDIS_RST && cfg_ff[5:2] == `FPC_THR_RST && st_ff == fpc_pkg::ST_IDLE;
  endproperty
  a_unlock: assert property (p_unlock) else $error("soft reset left config");

  property p_fill;
    (st_ff == fpc_pkg::ST_XFER && byte_ev && !soft_rst_w && byte_idx_ff >= host_len_w)
      |=> fill_byte_o && !host_byte_o;
  endproperty
  a_fill: assert property (p_fill) else $error("remainder passed to host");

  property p_latch;
    s_busy2 |-> $stable(ex_cyl_ff) && $stable(ex_eot_ff) && $stable(ex_n_ff) && $stable(ex_dtl_ff);
  endproperty
  a_latch: assert property (p_latch) else $error("parameter moved during command");
endmodule // fpc_top
`default_nettype wire

// ===== shared/fpc_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes a 250 MHz clock and a byte-addressed 32-bit Wishbone slave
`ifndef FPC_MAP_SVH
`define FPC_MAP_SVH
`define FPC_A_CFG      8'h00
`define FPC_A_TIM      8'h04
`define FPC_A_CMDA     8'h08
`define FPC_A_CMDB     8'h0C
`define FPC_A_CTRL     8'h10
`define FPC_A_STAT     8'h14
`define FPC_A_CNT      8'h18
`define FPC_CFG_MASK   32'h0000FFBF
`define FPC_TIM_MASK   32'h0000FFFF
`define FPC_CMDA_MASK  32'h3FFF01FF
`define FPC_CMDB_MASK  32'hFFFFFFFF
`define FPC_CFG_FDIS   0
`define FPC_CFG_SEEK   1
`define FPC_CFG_LOCK   7
`define FPC_CMDA_HEAD  8
`define FPC_CMDA_MT    27
`define FPC_CMDA_MFM   28
`define FPC_CMDA_WR    29
`define FPC_CMDB_PERP  24
`define FPC_CTRL_GO    0
`define FPC_CTRL_ORST  1
`define FPC_CTRL_RRST  2
`define FPC_FDIS_RST   1'b1
`define FPC_THR_RST    4'h0
`define FPC_PRE_RST    8'h00
`define FPC_GAP2_DEF   8'h16
`define FPC_BASE_LEN   15'h0080
`define FPC_FIRST_SEC  8'h01
`define FPC_CLK_NS     4
`define FPC_UNIT_NS    1000
`define FPC_UNIT_CYC   ((`FPC_UNIT_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_STEP_NS    2000
`define FPC_STEP_CYC   ((`FPC_STEP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`endif

// ===== shared/fpc_pkg.sv
// Types shared by the command sequencer files
// Assumes fpc_map.svh supplies all numeric constants
package fpc_pkg;
  typedef enum logic [4:0]
  {
    ST_IDLE  = 5'h01,
    ST_SEEK  = 5'h02,
    ST_HLOAD = 5'h04,
    ST_XFER  = 5'h08,
    ST_DONE  = 5'h10
  } fpc_state_t;
  typedef logic [14:0] fpc_len_t;
endpackage

// ===== verif/fpc_drive_model.sv
// Drive side model: one byte slot strobe per slot while enabled
// Assumes the bench enables it only around a command
`timescale 1ns/100ps
`default_nettype none
module fpc_drive_model
(
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic slow_i,
  output logic      byte_rdy_o
);
  logic [2:0] cnt_ff;
  // Halves of 2 or 4 clocks; pin rests low between frames
  always_ff @(posedge clk_i)
  begin
    if (!en_i)
    begin
      cnt_ff     <= 3'h0;
      byte_rdy_o <= 1'b0;
    end
    else if (cnt_ff == (slow_i ? 3'h3 : 3'h1))
    begin
      cnt_ff     <= 3'h0;
      byte_rdy_o <= ~byte_rdy_o;
    end
    else
    begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
endmodule // fpc_drive_model
`default_nettype wire

// ===== verif/tb_top.sv
// Bench for the command parameter sequencer, driven over Wishbone
// Assumes fpc_map.svh offsets and the drive model for byte slots
`timescale 1ns/100ps
`default_nettype none
`include "fpc_map.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, drv_en, drv_slow, rdy;
  logic [3:0] sel, thr;
  logic [7:0] adr, pre, gap2, gap3;
  logic [31:0] dat, rdat, q;
  logic ack, hl, side, step, dir, mfm, wr, fen, hb, fb, wr_seen, side_seen, dir_seen;
  int num_errors, total_checks, hb_cnt, fb_cnt, step_cnt;
  ////////////////////////////////////////////////////////////////////
  fpc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .byte_rdy_i(rdy), .head_load_o(hl), .side_o(side), .step_o(step), .dir_o(dir),
    .mfm_o(mfm), .write_o(wr), .fifo_en_o(fen), .fifo_thr_o(thr), .precomp_trk_o(pre),
    .gap2_o(gap2), .gap3_o(gap3), .host_byte_o(hb), .fill_byte_o(fb));
  fpc_drive_model drv (.clk_i(clk_i), .en_i(drv_en), .slow_i(drv_slow), .byte_rdy_o(rdy));
  // Clock at 250 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Pulse counters seen at the drive side
  always @(posedge clk_i)
  begin
    hb_cnt   += int'(hb === 1'b1);
    fb_cnt   += int'(fb === 1'b1);
    step_cnt += int'(step === 1'b1);
    if (wr === 1'b1)
    begin
      wr_seen   = 1'b1;
      side_seen = side;
    end
    // Direction only matters while a step pulse goes out
    if (step === 1'b1)
      dir_seen = dir;
  end
  ////////////////////////////////////////////////////////////////////
  // One classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 50)
    begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1) num_errors++;
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // Poll status until the busy bit clears, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    q = 32'h00000001;
    while (q[0] !== 1'b0 && n < 3000)
    begin
      wb(1'b0, `FPC_A_STAT, 32'h00000000);
      n++;
    end
    if (q[0] !== 1'b0) num_errors++;
    drv_en <= 1'b0;
  endtask
  task automatic start_cmd(input logic [31:0] a, input logic [31:0] b);
    hb_cnt = 0; fb_cnt = 0; step_cnt = 0; wr_seen = 1'b0; dir_seen = 1'b0;
    wb(1'b1, `FPC_A_CMDA, a);
    wb(1'b1, `FPC_A_CMDB, b);
    drv_en <= 1'b1;
    wb(1'b1, `FPC_A_CTRL, 32'h00000001);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the expected span
  initial
  begin
    repeat (60000) @(posedge clk_i);
    num_errors++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    num_errors = 0; total_checks = 0; hb_cnt = 0; fb_cnt = 0; step_cnt = 0;
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'h0; adr = 8'h00;
    dat = 32'h00000000; drv_en = 1'b0; drv_slow = 1'b0; wr_seen = 1'b0; side_seen = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `FPC_A_CFG, 32'h00000000);
    `CHK(q, 32'h00000001)
    `CHK(fen, 1'b0)
    wb(1'b0, 8'h1C, 32'h00000000);
    `CHK(q, 32'h00000000)
    $display("test reset_values done");
    // Locked soft reset keeps config, unlocked one restores it
    wb(1'b1, `FPC_A_CFG, 32'h00003C94);
    wb(1'b1, `FPC_A_CTRL, 32'h00000002);
    `CHK(fen, 1'b1)
    `CHK({thr, pre}, 12'h53C)
    wb(1'b1, `FPC_A_CFG, 32'h00003C14);
    wb(1'b1, `FPC_A_CTRL, 32'h00000004);
    wb(1'b0, `FPC_A_CFG, 32'h00000000);
    `CHK(q, 32'h00000001)
    `CHK({fen, thr, pre}, 13'h0000)
    $display("test soft_reset done");
    // Code 0, length 17, multi-track, perpendicular, one sector a side
    wb(1'b1, `FPC_A_TIM, 32'h00000100);
    start_cmd(32'h18010000, 32'h11201B01);
    wait_idle();
    `CHK(hb_cnt, 34)
    `CHK(fb_cnt, 222)
    wb(1'b0, `FPC_A_CNT, 32'h00000000);
    `CHK(q[15:0], 16'h0022)
    `CHK({mfm, gap2, gap3}, 17'h1201B)
    `CHK(hl, 1'b1)
    repeat (300) @(posedge clk_i);
    `CHK(hl, 1'b0)
    $display("test multi_track_short done");
    // Implied seek to cylinder 2, code 1 write on head 1, slow drive
    wb(1'b1, `FPC_A_CFG, 32'h00000002);
    drv_slow <= 1'b1;
    start_cmd(32'h21010102, 32'h00201B01);
    wb(1'b1, `FPC_A_CMDB, 32'h00FF3305);
    wait_idle();
    `CHK(step_cnt, 2)
    `CHK(dir_seen, 1'b1)
    `CHK(hb_cnt, 256)
    `CHK(fb_cnt, 0)
    `CHK({mfm, gap2, gap3}, 17'h0161B)
    `CHK(gap3, 8'h1B)
    `CHK({wr_seen, side_seen}, 2'h3)
    $display("test seek_write done");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
